/* File: logic/btm_pkg.sv */
// shared constants of the branch trace and break match block
package btm_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_A_ADDR = 8'h04;
  localparam logic [7:0] OFS_A_AMASK = 8'h08;
  localparam logic [7:0] OFS_A_DATA = 8'h0C;
  localparam logic [7:0] OFS_A_DMASK = 8'h10;
  localparam logic [7:0] OFS_A_CFG = 8'h14;
  localparam logic [7:0] OFS_B_ADDR = 8'h18;
  localparam logic [7:0] OFS_B_AMASK = 8'h1C;
  localparam logic [7:0] OFS_B_DATA = 8'h20;
  localparam logic [7:0] OFS_B_DMASK = 8'h24;
  localparam logic [7:0] OFS_B_CFG = 8'h28;
  localparam logic [7:0] OFS_EXEC_CNT = 8'h2C;
  localparam logic [7:0] OFS_TRACE_SRC = 8'h30;
  localparam logic [7:0] OFS_TRACE_DST = 8'h34;
  localparam logic [7:0] OFS_STATUS = 8'h38;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h3C;
  // ==========================================================
  // control register fields
  localparam int CTRL_TRACE_EN = 0;
  localparam int CTRL_SEQ = 1;
  // channel config fields
  localparam int CFG_RW_LO = 0;
  localparam int CFG_SIZE_LO = 2;
  localparam int CFG_FETCH = 4;
  localparam int CFG_POST = 5;
  localparam int CFG_EN = 6;
  localparam int CFG_W = 7;
  // status / mask fields
  localparam int ST_MATCH_A = 0;
  localparam int ST_MATCH_B = 1;
  localparam int ST_BREAK = 2;
  localparam int ST_W = 3;
  // ==========================================================
  // size encodings: config (00 = size not compared) and bus
  localparam logic [1:0] CSZ_NONE = 2'h0;
  localparam logic [1:0] CSZ_BYTE = 2'h1;
  localparam logic [1:0] CSZ_WORD = 2'h2;
  localparam logic [1:0] CSZ_LONG = 2'h3;
  localparam logic [1:0] BSZ_BYTE = 2'h0;
  localparam logic [1:0] BSZ_WORD = 2'h1;
  localparam logic [1:0] BSZ_LONG = 2'h2;
  // ==========================================================
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [CFG_W-1:0] RST_CFG = 7'h00;
  localparam logic [15:0] RST_EXEC_CNT = 16'h0000;
  typedef enum logic [1:0] {
    BTM_WB_IDLE = 2'b01,
    BTM_WB_ACK = 2'b10
  } btm_wb_state_t;
endpackage : btm_pkg

/* File: logic/btm_top.sv */
// branch trace queue and two-channel break matcher with wishbone registers
`timescale 1ns/1ps

// Summary of operation
// - trace only while trace enable set
// - branch insn: own address, then target
// - exception: stacked pc, then handler start
// - queue holds four pairs, eight optional
// - oldest first, advance on target read
// - re-enabling trace invalidates queue contents
// - post-execution break after instruction completes
// - address mask ones drop address bits
// - masked low bits cover even span
// - write-qualified fetch channel never matches
// - odd byte-exact fetch address never matches
// - sequential: B fires only after A
// - count five: break before fifth execution
// - size excluded: access size picks alignment
// - masked address plus word data write
// - data mask ones drop data bits
// - compare 31:2 long, 31:1 word, 31:0 byte
module btm_top #(
  parameter int DEPTH = 4,
  parameter int CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // cpu bus observation
  input wire logic cyc_valid_i,
  input wire logic cyc_fetch_i,
  input wire logic cyc_write_i,
  input wire logic [1:0] cyc_size_i,
  input wire logic [31:0] cyc_addr_i,
  input wire logic [31:0] cyc_data_i,
  input wire logic insn_done_i,
  // branch events
  input wire logic branch_i,
  input wire logic branch_exc_i,
  input wire logic [31:0] branch_pc_i,
  input wire logic [31:0] stacked_pc_i,
  input wire logic [31:0] branch_dst_i,
  // outputs
  output logic break_o,
  output logic irq_o
);
  import btm_pkg::*;

  localparam int PW = $clog2(DEPTH);

  // ==========================================================
  // matcher for one channel
  // bar/bam: address and mask, bdr/bdm: data and mask
  // purely combinational, so a hit shows in the cycle it is seen
  function automatic logic chan_match(
    input logic [31:0] bar, input logic [31:0] bam,
    input logic [31:0] bdr, input logic [31:0] bdm,
    input logic [CFG_W-1:0] cfg,
    input logic fetch, input logic wr, input logic [1:0] bsz,
    input logic [31:0] addr, input logic [31:0] data);
    logic [31:0] szm;
    logic [31:0] dm;
    logic [1:0] csz;
    logic rw_ok;
    logic sz_ok;
    logic a_ok;
    logic d_ok;
    // operand size narrows the address compare on data cycles
    csz = cfg[CFG_SIZE_LO +: 2];
    szm = 32'hFFFF_FFFF;
    if (!fetch) begin
      if (bsz == BSZ_LONG) begin
        szm = 32'hFFFF_FFFC;
      end else if (bsz == BSZ_WORD) begin
        szm = 32'hFFFF_FFFE;
      end
    end
    // fetch compares all bits, so an odd target can never hit
    a_ok = (((bar ^ addr) & ~bam & szm) == 32'h0000_0000);
    // fetches are reads regardless of what the bus claims
    rw_ok = ((fetch || !wr) && cfg[CFG_RW_LO]) || (!fetch && wr && cfg[CFG_RW_LO+1]);
    // a size given in the config must equal the bus size
    sz_ok = (csz == CSZ_NONE) || (csz == CSZ_BYTE && bsz == BSZ_BYTE) ||
            (csz == CSZ_WORD && bsz == BSZ_WORD) || (csz == CSZ_LONG && bsz == BSZ_LONG);
    // byte and word data sit in the low lanes
    dm = 32'hFFFF_FFFF;
    if (csz == CSZ_BYTE) begin
      dm = 32'h0000_00FF;
    end else if (csz == CSZ_WORD) begin
      dm = 32'h0000_FFFF;
    end
    // data only counts on data cycles with a size given
    d_ok = fetch || (csz == CSZ_NONE) || ((((bdr ^ data) & ~bdm & dm)) == 32'h0000_0000);
    // every qualifier must agree for a hit
    chan_match = cfg[CFG_EN] && (cfg[CFG_FETCH] == fetch) && a_ok && rw_ok && sz_ok && d_ok;
  endfunction : chan_match

  // ==========================================================
  // registers
  logic [1:0] ctrl_r;
  // channel A condition
  logic [31:0] chan_a_break_address_r;
  logic [31:0] chan_a_address_mask_r;
  logic [31:0] chan_a_data_r;
  logic [31:0] chan_a_data_mask_r;
  logic [CFG_W-1:0] chan_a_cycle_select_r;
  // channel B condition
  logic [31:0] chan_b_address_r;
  logic [31:0] chan_b_address_mask_r;
  logic [31:0] chan_b_data_r;
  logic [31:0] chan_b_data_mask_r;
  logic [CFG_W-1:0] chan_b_cycle_select_r;
  // count setting, status, mask and bus state
  logic [CNT_W-1:0] execution_count_setting_r;
  logic [ST_W-1:0] status_r;
  logic [ST_W-1:0] irq_mask_r;
  btm_wb_state_t wb_state_r;
  // trace storage, one array per half of each pair
  logic [31:0] src_q [DEPTH];
  logic [31:0] dst_q [DEPTH];
  logic [PW-1:0] head_r;
  logic [PW:0] cnt_r;
  // break sequencing state
  logic seq_armed_r;
  logic [CNT_W-1:0] exec_cnt_r;
  logic post_pend_r;

  // ==========================================================
  // bus decode
  wire logic req = wb_cyc_i && wb_stb_i && (wb_state_r == BTM_WB_IDLE);
  wire logic wr_en = req && wb_we_i && (wb_sel_i == 4'hF);
  wire logic rd_en = req && !wb_we_i;
  // register selects shared by writes, pops and clears
  wire logic sel_ctrl = (wb_adr_i == OFS_CTRL);
  wire logic sel_trace_dst = (wb_adr_i == OFS_TRACE_DST);
  wire logic sel_status = (wb_adr_i == OFS_STATUS);
  wire logic pop = rd_en && sel_trace_dst && (cnt_r != '0);
  wire logic trace_en = ctrl_r[CTRL_TRACE_EN];
  // only a 0 to 1 step of the enable empties the queue
  wire logic trace_on_edge = wr_en && sel_ctrl && wb_dat_i[CTRL_TRACE_EN] && !trace_en;

  // channel matches on the observed cycle
  // both channels share one matcher, so they behave alike
  wire logic hit_a = cyc_valid_i && chan_match(chan_a_break_address_r, chan_a_address_mask_r, chan_a_data_r,
    chan_a_data_mask_r, chan_a_cycle_select_r, cyc_fetch_i, cyc_write_i, cyc_size_i, cyc_addr_i, cyc_data_i);
  wire logic hit_b = cyc_valid_i && chan_match(chan_b_address_r, chan_b_address_mask_r, chan_b_data_r,
    chan_b_data_mask_r, chan_b_cycle_select_r, cyc_fetch_i, cyc_write_i, cyc_size_i, cyc_addr_i, cyc_data_i);
  wire logic seq_mode = ctrl_r[CTRL_SEQ];
  // counting channel A: zero or one setting breaks on first hit
  wire logic cnt_fire = (execution_count_setting_r <= {{(CNT_W-1){1'b0}}, 1'b1}) ||
                        (exec_cnt_r + 1'b1 == execution_count_setting_r);
  wire logic fire_a = hit_a && !seq_mode && cnt_fire;
  // same-cycle A and B do not form a sequence
  wire logic fire_b = hit_b && (!seq_mode || seq_armed_r);
  // pre breaks stop a fetch itself; all else waits for completion
  wire logic fire_pre = (fire_a && !chan_a_cycle_select_r[CFG_POST] && chan_a_cycle_select_r[CFG_FETCH]) ||
                        (fire_b && !chan_b_cycle_select_r[CFG_POST] && chan_b_cycle_select_r[CFG_FETCH]);
  wire logic fire_post = (fire_a || fire_b) && !fire_pre;
  wire logic brk = fire_pre || (post_pend_r && insn_done_i);

  // trace queue pointers
  // branches while disabled are lost, not held
  wire logic push = branch_i && trace_en;
  // pointer sums wrap, so DEPTH must be a power of two
  wire logic full = (cnt_r == (PW+1)'(DEPTH));
  wire logic [PW-1:0] wr_ptr = PW'(head_r + cnt_r[PW-1:0]);
  // head moves on a pop or when a full queue drops its oldest
  wire logic [PW-1:0] head_nxt = (pop || (push && full)) ? PW'(head_r + 1'b1) : head_r;

  // ==========================================================
  // wishbone handshake: ack one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_state_r <= BTM_WB_IDLE;
    end else begin
      case (wb_state_r)
        BTM_WB_IDLE: wb_state_r <= (wb_cyc_i && wb_stb_i) ? BTM_WB_ACK : BTM_WB_IDLE;
        BTM_WB_ACK: wb_state_r <= BTM_WB_IDLE;
        default: wb_state_r <= BTM_WB_IDLE;
      endcase
    end
  end
  // fixed latency; no request is taken while ack is high
  assign wb_ack_o = (wb_state_r == BTM_WB_ACK);

  // read mux, registered so data lines up with ack
  logic [31:0] rd_mux;
  always_comb begin
    case (wb_adr_i)
      OFS_CTRL: rd_mux = {30'h0000_0000, ctrl_r};
      OFS_A_ADDR: rd_mux = chan_a_break_address_r;
      OFS_A_AMASK: rd_mux = chan_a_address_mask_r;
      OFS_A_DATA: rd_mux = chan_a_data_r;
      OFS_A_DMASK: rd_mux = chan_a_data_mask_r;
      OFS_A_CFG: rd_mux = {25'h000_0000, chan_a_cycle_select_r};
      OFS_B_ADDR: rd_mux = chan_b_address_r;
      OFS_B_AMASK: rd_mux = chan_b_address_mask_r;
      OFS_B_DATA: rd_mux = chan_b_data_r;
      OFS_B_DMASK: rd_mux = chan_b_data_mask_r;
      OFS_B_CFG: rd_mux = {25'h000_0000, chan_b_cycle_select_r};
      OFS_EXEC_CNT: rd_mux = 32'(execution_count_setting_r);
      // an empty queue reads zero so stale pairs never leak
      OFS_TRACE_SRC: rd_mux = (cnt_r != '0) ? src_q[head_r] : RST_WORD;
      OFS_TRACE_DST: rd_mux = (cnt_r != '0) ? dst_q[head_r] : RST_WORD;
      OFS_STATUS: rd_mux = {29'h0000_0000, status_r};
      OFS_IRQ_MASK: rd_mux = {29'h0000_0000, irq_mask_r};
      // unmapped offsets read zero
      default: rd_mux = RST_WORD;
    endcase
  end

  // read data stays put between reads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= RST_WORD;
    end else if (rd_en) begin
      wb_dat_o <= rd_mux;
    end
  end

  // ==========================================================
  // software-written configuration; partial-lane writes are ignored
  // limitation: byte-lane writes are dropped, not merged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= 2'h0;
      chan_a_break_address_r <= RST_WORD;
      chan_a_address_mask_r <= RST_WORD;
      chan_a_data_r <= RST_WORD;
      chan_a_data_mask_r <= RST_WORD;
      chan_a_cycle_select_r <= RST_CFG;
      chan_b_address_r <= RST_WORD;
      chan_b_address_mask_r <= RST_WORD;
      chan_b_data_r <= RST_WORD;
      chan_b_data_mask_r <= RST_WORD;
      chan_b_cycle_select_r <= RST_CFG;
      execution_count_setting_r <= CNT_W'(RST_EXEC_CNT);
      irq_mask_r <= '0;
    end else if (wr_en) begin
      case (wb_adr_i)
        OFS_CTRL: ctrl_r <= wb_dat_i[1:0];
        OFS_A_ADDR: chan_a_break_address_r <= wb_dat_i;
        OFS_A_AMASK: chan_a_address_mask_r <= wb_dat_i;
        OFS_A_DATA: chan_a_data_r <= wb_dat_i;
        OFS_A_DMASK: chan_a_data_mask_r <= wb_dat_i;
        OFS_A_CFG: chan_a_cycle_select_r <= wb_dat_i[CFG_W-1:0];
        OFS_B_ADDR: chan_b_address_r <= wb_dat_i;
        OFS_B_AMASK: chan_b_address_mask_r <= wb_dat_i;
        OFS_B_DATA: chan_b_data_r <= wb_dat_i;
        OFS_B_DMASK: chan_b_data_mask_r <= wb_dat_i;
        OFS_B_CFG: chan_b_cycle_select_r <= wb_dat_i[CFG_W-1:0];
        OFS_EXEC_CNT: execution_count_setting_r <= wb_dat_i[CNT_W-1:0];
        OFS_IRQ_MASK: irq_mask_r <= wb_dat_i[ST_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // sticky status: a new event beats a same-cycle clear
  // raw hits are flagged even when no break follows
  wire logic [ST_W-1:0] st_set = {brk, hit_b, hit_a};
  wire logic [ST_W-1:0] st_clr = (wr_en && sel_status) ? wb_dat_i[ST_W-1:0] : '0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~st_clr) | st_set;
    end
  end
  // level output straight from registers, no edge memory
  assign irq_o = |(status_r & irq_mask_r);
  assign break_o = brk;

  // ==========================================================
  // sequence arm, execution counter, post-execution pending
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_armed_r <= 1'b0;
      exec_cnt_r <= '0;
      post_pend_r <= 1'b0;
    end else begin
      // leaving sequential mode drops a pending A hit
      if (!seq_mode || fire_b) begin
        seq_armed_r <= 1'b0;
      end else if (hit_a && !hit_b) begin
        seq_armed_r <= 1'b1;
      end
      // counting only in independent mode
      if (hit_a && !seq_mode) begin
        exec_cnt_r <= cnt_fire ? '0 : exec_cnt_r + 1'b1;
      end
      // a fire in a completion cycle waits for the next completion
      if (fire_post) begin
        post_pend_r <= 1'b1;
      end else if (insn_done_i) begin
        post_pend_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // trace queue: circular pairs, head is oldest
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      head_r <= '0;
      cnt_r <= '0;
    end else if (trace_on_edge) begin
      // earlier records are not kept across a re-enable
      head_r <= '0;
      cnt_r <= '0;
    end else begin
      head_r <= head_nxt;
      // push and pop together leave the count as it is
      if (push && !pop && !full) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // queue storage; no reset needed, empty entries are never shown
  always_ff @(posedge clk_i) begin
    if (push) begin
      // a full push lands on the oldest slot, now the newest
      src_q[wr_ptr] <= branch_exc_i ? stacked_pc_i : branch_pc_i;
      dst_q[wr_ptr] <= branch_dst_i;
    end
  end
endmodule : btm_top

/* File: tb/btm_sva.sv */
// port-level assertion checker for the trace and break block
`timescale 1ns/1ps
module btm_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic cyc_valid_i,
  input wire logic cyc_fetch_i,
  input wire logic insn_done_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic break_o,
  input wire logic irq_o
);
  // ==========================================================
  // bus answer: fixed one-cycle latency and one-cycle pulse
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_lat; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack not one cycle after request");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_ack_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
  // read data only moves when a read is taken
  property p_dat_hold; !(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) |=> $stable(wb_dat_o); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved without a read");
  // ==========================================================
  // break request has a cause in the same cycle
  property p_brk_src; break_o |-> cyc_valid_i || insn_done_i; endproperty
  a_brk_src: assert property (p_brk_src) else $error("break without bus cycle or completion");
  property p_brk_pre; break_o && !insn_done_i |-> cyc_valid_i && cyc_fetch_i; endproperty
  a_brk_pre: assert property (p_brk_pre) else $error("early break not on a fetch");
  // interrupt level only moves after a write or a cpu event
  property p_irq_rise; $rose(irq_o) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i || cyc_valid_i || insn_done_i);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_irq_fall; $fell(irq_o) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
  c_brk: cover property (break_o);
  c_irq: cover property ($rose(irq_o));
  c_read: cover property (wb_ack_o && !wb_we_i);
endmodule : btm_sva

bind btm_top btm_sva u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .cyc_valid_i, .cyc_fetch_i,
  .insn_done_i, .wb_dat_o, .wb_ack_o, .break_o, .irq_o);

/* File: tb/btm_cpu_model.sv */
// behavioural cpu core: bus cycles, completions and branches
`timescale 1ns/1ps
module btm_cpu_model (
  input wire logic clk_i,
  input wire logic brk_i,
  output logic cyc_valid_o,
  output logic cyc_fetch_o,
  output logic cyc_write_o,
  output logic [1:0] cyc_size_o,
  output logic [31:0] cyc_addr_o,
  output logic [31:0] cyc_data_o,
  output logic insn_done_o,
  output logic branch_o,
  output logic branch_exc_o,
  output logic [31:0] branch_pc_o,
  output logic [31:0] stacked_pc_o,
  output logic [31:0] branch_dst_o
);
  // ==========================================================
  // quiet core at time zero
  initial begin
    {cyc_valid_o, cyc_fetch_o, cyc_write_o, cyc_size_o, insn_done_o, branch_o, branch_exc_o} = '0;
    {cyc_addr_o, cyc_data_o, branch_pc_o, stacked_pc_o, branch_dst_o} = '0;
  end
  // access, then completion; break seen in each cycle
  // released lines are inverted so stale values never look valid
  task automatic step(input logic f, input logic w, input logic [1:0] sz, input logic [31:0] a,
      input logic [31:0] d, output logic [1:0] hit);
    @(posedge clk_i);
    {cyc_valid_o, cyc_fetch_o, cyc_write_o, cyc_size_o, cyc_addr_o, cyc_data_o} <= {1'b1, f, w, sz, a, d};
    @(negedge clk_i);
    hit[1] = brk_i;
    @(posedge clk_i);
    {cyc_valid_o, cyc_addr_o, cyc_data_o, insn_done_o} <= {1'b0, ~a, ~d, 1'b1};
    @(negedge clk_i);
    hit[0] = brk_i;
    @(posedge clk_i);
    insn_done_o <= 1'b0;
  endtask : step
  // one-cycle branch event
  task automatic jump(input logic exc, input logic [31:0] pc, input logic [31:0] stk, input logic [31:0] dst);
    @(posedge clk_i);
    {branch_o, branch_exc_o, branch_pc_o, stacked_pc_o, branch_dst_o} <= {1'b1, exc, pc, stk, dst};
    @(posedge clk_i);
    {branch_o, branch_pc_o, stacked_pc_o, branch_dst_o} <= {1'b0, ~pc, ~stk, ~dst};
  endtask : jump
endmodule : btm_cpu_model

/* File: tb/test_branch_trace_and_break_match.sv */
// self-checking bench for the branch trace and break match block
`timescale 1ns/1ps
module test_branch_trace_and_break_match;
  import btm_pkg::*;
  // ==========================================================
  // nets, counters and clock
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic cyc_valid_i, cyc_fetch_i, cyc_write_i, insn_done_i, branch_i, branch_exc_i, wb_ack_o, break_o, irq_o;
  logic [1:0] cyc_size_i, h;
  logic [31:0] cyc_addr_i, cyc_data_i, branch_pc_i, stacked_pc_i, branch_dst_i, wb_dat_o, q;
  logic [31:0] zero = 32'h0000_0000;
  int num_errors = 0, tests_run = 0;
  always #25 clk_i = ~clk_i;
  // ==========================================================
  // design and cpu model
  btm_top #(.DEPTH(4), .CNT_W(16)) u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .cyc_valid_i, .cyc_fetch_i, .cyc_write_i, .cyc_size_i, .cyc_addr_i,
    .cyc_data_i, .insn_done_i, .branch_i, .branch_exc_i, .branch_pc_i, .stacked_pc_i, .branch_dst_i, .break_o,
    .irq_o);
  btm_cpu_model u_cpu (.clk_i, .brk_i(break_o), .cyc_valid_o(cyc_valid_i), .cyc_fetch_o(cyc_fetch_i),
    .cyc_write_o(cyc_write_i), .cyc_size_o(cyc_size_i), .cyc_addr_o(cyc_addr_i), .cyc_data_o(cyc_data_i),
    .insn_done_o(insn_done_i), .branch_o(branch_i), .branch_exc_o(branch_exc_i), .branch_pc_o(branch_pc_i),
    .stacked_pc_o(stacked_pc_i), .branch_dst_o(branch_dst_i));
  // ==========================================================
  // compare, bus cycle and helpers
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  // classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, s};
    // no local limit: only the watchdog ends a wait
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, zero, 4'hF);
    cmp($sformatf("reg %h", a), e, q);
  endtask : rd
  task automatic chan(input logic [7:0] b, input logic [31:0] a, am, d, dm, input logic [7:0] c);
    wr(b, a);
    wr(b + 8'h04, am);
    wr(b + 8'h08, d);
    wr(b + 8'h0C, dm);
    wr(b + 8'h10, 32'(c));
  endtask : chan
  task automatic clr;
    wr(OFS_A_CFG, zero);
    wr(OFS_B_CFG, zero);
    wr(OFS_EXEC_CNT, zero);
    wr(OFS_STATUS, 32'h0000_0007);
  endtask : clr
  // expected break pair: {at access, at completion}
  task automatic brk(input logic f, w, input logic [1:0] sz, input logic [31:0] a, d, input logic [1:0] e);
    u_cpu.step(f, w, sz, a, d, h);
    cmp("break", 32'(e), 32'(h));
  endtask : brk
  task automatic print_verdict;
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // ==========================================================
  // hang guard, well beyond the expected run
  initial begin
    repeat (6000) @(posedge clk_i);
    num_errors++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int o = 0; o <= 64; o += 4) rd(8'(o), zero);
    wb(1'b1, OFS_CTRL, 32'h0000_0001, 4'h7);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(OFS_CTRL, zero);
    rd(8'h40, zero);
    wr(OFS_IRQ_MASK, 32'h0000_0004);
    chan(OFS_A_ADDR, 32'h0000_0404, zero, zero, zero, 8'h71);
    brk(1'b1, 1'b0, BSZ_WORD, 32'h0000_0404, zero, 2'b01);
    rd(OFS_STATUS, 32'h0000_0005);
    cmp("irq", 32'h0000_0001, 32'(irq_o));
    wr(OFS_IRQ_MASK, zero);
    cmp("irq", zero, 32'(irq_o));
    wr(OFS_IRQ_MASK, 32'h0000_0004);
    clr();
    cmp("irq", zero, 32'(irq_o));
    chan(OFS_A_ADDR, 32'h0000_8404, 32'h0000_0FFF, zero, zero, 8'h71);
    brk(1'b1, 1'b0, BSZ_WORD, 32'h0000_8000, zero, 2'b01);
    brk(1'b1, 1'b0, BSZ_WORD, 32'h0000_8FFE, zero, 2'b01);
    brk(1'b1, 1'b0, BSZ_WORD, 32'h0000_9000, zero, 2'b00);
    clr();
    chan(OFS_B_ADDR, 32'h0000_8010, 32'h0000_0006, zero, zero, 8'h51);
    for (int a = 32'h8010; a <= 32'h8018; a += 2) brk(1'b1, 1'b0, BSZ_WORD, a, zero, {a < 32'h8018, 1'b0});
    clr();
    chan(OFS_A_ADDR, 32'h0002_7128, zero, zero, zero, 8'h5A);
    chan(OFS_B_ADDR, 32'h0003_1415, zero, zero, zero, 8'h51);
    brk(1'b1, 1'b0, BSZ_WORD, 32'h0002_7128, zero, 2'b00);
    brk(1'b1, 1'b0, BSZ_WORD, 32'h0003_1414, zero, 2'b00);
    brk(1'b1, 1'b0, BSZ_WORD, 32'h0003_1416, zero, 2'b00);
    clr();
    wr(OFS_CTRL, 32'h0000_0002);
    chan(OFS_A_ADDR, 32'h0003_7226, zero, zero, zero, 8'h59);
    chan(OFS_B_ADDR, 32'h0003_722E, zero, zero, zero, 8'h59);
    brk(1'b1, 1'b0, BSZ_WORD, 32'h0003_722E, zero, 2'b00);
    brk(1'b1, 1'b0, BSZ_WORD, 32'h0003_7226, zero, 2'b00);
    brk(1'b1, 1'b0, BSZ_WORD, 32'h0003_722E, zero, 2'b10);
    wr(OFS_CTRL, zero);
    clr();
    chan(OFS_A_ADDR, 32'h0000_0500, zero, zero, zero, 8'h5D);
    wr(OFS_EXEC_CNT, 32'h0000_0005);
    for (int i = 1; i <= 5; i++) brk(1'b1, 1'b0, BSZ_LONG, 32'h0000_0500, zero, {i == 5, 1'b0});
    clr();
    chan(OFS_A_ADDR, 32'h0012_3456, zero, 32'h1234_5678, 32'hFFFF_FFFF, 8'h41);
    brk(1'b0, 1'b0, BSZ_LONG, 32'h0012_3454, zero, 2'b01);
    brk(1'b0, 1'b0, BSZ_WORD, 32'h0012_3456, zero, 2'b01);
    brk(1'b0, 1'b0, BSZ_BYTE, 32'h0012_3456, zero, 2'b01);
    brk(1'b0, 1'b0, BSZ_BYTE, 32'h0012_3457, zero, 2'b00);
    clr();
    chan(OFS_B_ADDR, 32'h000A_BCDE, 32'h0000_00FF, 32'h0000_A512, zero, 8'h4A);
    brk(1'b0, 1'b1, BSZ_WORD, 32'h000A_BC00, 32'h0000_A512, 2'b01);
    brk(1'b0, 1'b1, BSZ_WORD, 32'h000A_BCFE, 32'h0000_A513, 2'b00);
    brk(1'b0, 1'b1, BSZ_WORD, 32'h000A_BD00, 32'h0000_A512, 2'b00);
    clr();
    chan(OFS_B_ADDR, 32'h0005_5555, zero, 32'h0000_0078, 32'h0000_000F, 8'h46);
    brk(1'b0, 1'b1, BSZ_BYTE, 32'h0005_5555, 32'h0000_0075, 2'b01);
    brk(1'b0, 1'b1, BSZ_BYTE, 32'h0005_5555, 32'h0000_0085, 2'b00);
    clr();
    // debug port stop and reset controls are assumed ready outside this block
    wr(OFS_CTRL, 32'h0000_0001);
    for (int i = 1; i <= 5; i++) u_cpu.jump(i == 3, 32'h0000_1000 + i, 32'h0000_2000 + i, 32'h0000_3000 + i);
    rd(OFS_TRACE_SRC, 32'h0000_1002);
    for (int i = 2; i <= 5; i++) begin
      rd(OFS_TRACE_SRC, i == 3 ? 32'h0000_2003 : 32'h0000_1000 + i);
      rd(OFS_TRACE_DST, 32'h0000_3000 + i);
    end
    rd(OFS_TRACE_DST, zero);
    u_cpu.jump(1'b0, 32'h0000_0A00, zero, 32'h0000_0B00);
    wr(OFS_CTRL, zero);
    u_cpu.jump(1'b0, 32'h0000_0C00, zero, 32'h0000_0D00);
    rd(OFS_TRACE_DST, 32'h0000_0B00);
    rd(OFS_TRACE_SRC, zero);
    wr(OFS_CTRL, 32'h0000_0001);
    u_cpu.jump(1'b0, 32'h0000_0E00, zero, zero);
    wr(OFS_CTRL, zero);
    wr(OFS_CTRL, 32'h0000_0001);
    rd(OFS_TRACE_SRC, zero);
    print_verdict();
  end
endmodule : test_branch_trace_and_break_match
